//--- lfm_alert.sv
`default_nettype none
module lfm_alert
  import lfm_pkg::*;
#(
  parameter int PULSE_CYC = ALERT_PULSE_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pulse_req,
  input  wire logic hold_req,
  output var  logic alert_oe
);

  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_CYC);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_alert_oe;

  always_comb begin
    next_cnt = cnt;
    // [R19] restart on event
    if (pulse_req) begin
      next_cnt = PULSE_LOAD;
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
    // [R19] steady pulldown overrides
    next_alert_oe = hold_req | (next_cnt != '0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt      <= '0;
      alert_oe <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      alert_oe <= next_alert_oe;
    end
  end

endmodule
`default_nettype wire

//--- lfm_fault_monitor.sv
// Function
// [R1] Supply recovery: reset to init, set power-on, error
// [R2] Power-on clear wipes power-on and error flags, reads zero
// [R3] Low supply: 50 us alert pulse, flags
// [R4] Fault flags latched until fault clear
// [R5] Master clears only after fault gone
// [R6] Low-supply threshold 4 V to 35 V, 1 V
// [R7] Low supply suppresses open detection
// [R8] Supply undervoltage: steady alert, flags
// [R9] Supply undervoltage disables all channel outputs
// [R10] Reference fault: steady alert until recovery, flags
// [R11] Master handles reference fault shutdown
// [R12] Thermal warning: 50 us pulse, flags
// [R13] Overtemperature: outputs off, steady alert, flags
// [R14] Thermal shutdown: alert, power-on flag, defaults
// [R15] Open monitoring only during on phase
// [R16] Open after blank plus deglitch: pulse, flags
// [R17] No corrective action on open fault
// [R18] Blanking set by 4-bit field
// [R19] Pulse counter restarts; steady overrides pulse
`default_nettype none
module lfm_fault_monitor
  import lfm_pkg::*;
#(
  parameter int N_CH      = NUM_CH,
  parameter int PULSE_CYC = ALERT_PULSE_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [DATA_W-1:0]   reg_rdata,
  input  wire logic                supply_ok,
  input  wire logic                thermal_shutdown,
  input  wire logic                low_supply_detect,
  input  wire logic                supply_uv_detect,
  input  wire logic                ref_fault_detect,
  input  wire logic                thermal_warn_detect,
  input  wire logic                overtemp_detect,
  input  wire logic [N_CH-1:0]     pwm_on,
  input  wire logic [N_CH-1:0]     headroom_low,
  input  wire logic                alert_in,
  output var  logic                alert_out,
  output var  logic                alert_oe,
  output var  logic [LOWSUP_W-1:0] low_supply_threshold_setting,
  output var  logic                channel_output_enable,
  output var  logic                open_detect_enable
);

  localparam logic [MON_CNT_W-1:0] DEG_CYC = MON_CNT_W'(OPEN_DEG_CYC);
  localparam logic [MON_CNT_W-1:0] STEP_CYC = MON_CNT_W'(BLANK_STEP_CYC);

  // Blanking code n gives (n+1) steps
  function automatic logic [MON_CNT_W-1:0] blank_to_cyc(
    input logic [BLANK_W-1:0] code
  );
    logic [MON_CNT_W-1:0] steps;
    steps = MON_CNT_W'(code) + MON_CNT_W'(1);
    return MON_CNT_W'(steps * STEP_CYC);
  endfunction

  lfm_state_t state;
  lfm_state_t next_state;

  logic [BLANK_W-1:0]  blank_code;
  logic [FLG_W-1:0]    flags;
  logic [N_CH-1:0]     open_flags;
  logic                prev_lowsup;
  logic                prev_twarn;
  logic [BLANK_W-1:0]  next_blank_code;
  logic [LOWSUP_W-1:0] next_lowsup_th;
  logic [FLG_W-1:0]    next_flags;
  logic [N_CH-1:0]     next_open_flags;
  logic [DATA_W-1:0]   next_rdata;
  logic                next_out_en;
  logic                next_open_en;

  logic                in_por;
  logic                por_clr;
  logic                fault_clr;
  logic [N_CH-1:0]     open_evt;
  logic                any_open;
  logic                pulse_req;
  logic                hold_req;
  logic                alert_oe_int;
  logic [MON_CNT_W-1:0] blank_cyc;

  assign in_por    = ~supply_ok | thermal_shutdown;
  assign por_clr   = reg_wr && (reg_addr == ADDR_CTRL) &&
                     reg_wdata[CTRL_POR_CLR_BIT];
  assign fault_clr = reg_wr && (reg_addr == ADDR_CTRL) &&
                     reg_wdata[CTRL_FAULT_CLR_BIT];
  assign any_open  = |open_evt;
  assign blank_cyc = blank_to_cyc(blank_code);

  // Power state
  always_comb begin
    next_state = state;
    case (state)
      LFM_POR: begin
        // [R1] recovery enters init
        if (!in_por) begin
          next_state = LFM_INIT;
        end
      end
      LFM_INIT: begin
        next_state = in_por ? LFM_POR : LFM_NORMAL;
      end
      LFM_NORMAL: begin
        // [R14] shutdown restarts from reset
        if (in_por) begin
          next_state = LFM_POR;
        end
      end
      default: begin
        next_state = LFM_POR;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= LFM_POR;
    end else begin
      state <= next_state;
    end
  end

  // Open detectors, one per channel
  genvar ch;
  generate
    for (ch = 0; ch < N_CH; ch++) begin : g_ch
      lfm_open_det #(
        .CNT_W (MON_CNT_W)
      ) u_open (
        .mclk         (mclk),
        .rst          (rst),
        .pwm_on       (pwm_on[ch]),
        .headroom_low (headroom_low[ch]),
        .det_enable   (open_detect_enable),
        .blank_cyc    (blank_cyc),
        .deg_cyc      (DEG_CYC),
        .open_evt     (open_evt[ch])
      );
    end
  endgenerate

  // Pulsed events versus steady pulldown
  always_comb begin
    // [R3] [R12] [R16] edge-triggered pulse
    pulse_req = (state == LFM_NORMAL) &&
                (lfm_rise(low_supply_detect, prev_lowsup) ||
                 lfm_rise(thermal_warn_detect, prev_twarn) || any_open);
    // [R8] [R10] [R13] [R14] steady while present
    hold_req  = thermal_shutdown ||
                ((state == LFM_NORMAL) &&
                 (supply_uv_detect || ref_fault_detect || overtemp_detect));
  end

  lfm_alert #(
    .PULSE_CYC (PULSE_CYC)
  ) u_alert (
    .mclk      (mclk),
    .rst       (rst),
    .pulse_req (pulse_req),
    .hold_req  (hold_req),
    .alert_oe  (alert_oe_int)
  );

  assign alert_oe = alert_oe_int;

  // Configuration, flags, outputs and read data
  always_comb begin
    next_blank_code = blank_code;
    next_lowsup_th  = low_supply_threshold_setting;
    next_flags      = flags;
    next_open_flags = open_flags;
    next_rdata      = '0;

    if (reg_wr && reg_addr == ADDR_CONFIG) begin
      // [R6] code 0..31 maps 4 V..35 V
      next_lowsup_th  = reg_wdata[CFG_LOWSUP_LSB +: LOWSUP_W];
      // [R18] blanking field
      next_blank_code = reg_wdata[CFG_BLANK_LSB +: BLANK_W];
    end

    // Clears first, so a set in the same cycle wins
    // [R2] power-on clear
    if (por_clr) begin
      next_flags[FLG_POR] = 1'b0;
      next_flags[FLG_ERR] = 1'b0;
    end
    // [R4] [R5] fault clear
    if (fault_clr) begin
      next_flags[FLG_LOWSUP] = 1'b0;
      next_flags[FLG_SUPUV]  = 1'b0;
      next_flags[FLG_REF]    = 1'b0;
      next_flags[FLG_TWARN]  = 1'b0;
      next_flags[FLG_OTEMP]  = 1'b0;
      next_flags[FLG_OUT]    = 1'b0;
      next_flags[FLG_ERR]    = 1'b0;
      next_open_flags        = '0;
    end

    if (state == LFM_NORMAL) begin
      // [R3] low supply
      if (low_supply_detect) begin
        next_flags[FLG_LOWSUP] = 1'b1;
        next_flags[FLG_ERR]    = 1'b1;
      end
      // [R8] supply undervoltage
      if (supply_uv_detect) begin
        next_flags[FLG_SUPUV] = 1'b1;
        next_flags[FLG_ERR]   = 1'b1;
      end
      // [R10] reference fault
      if (ref_fault_detect) begin
        next_flags[FLG_REF] = 1'b1;
        next_flags[FLG_ERR] = 1'b1;
      end
      // [R12] thermal warning
      if (thermal_warn_detect) begin
        next_flags[FLG_TWARN] = 1'b1;
        next_flags[FLG_ERR]   = 1'b1;
      end
      // [R13] overtemperature
      if (overtemp_detect) begin
        next_flags[FLG_OTEMP] = 1'b1;
        next_flags[FLG_ERR]   = 1'b1;
      end
      // [R16] per-channel open
      if (any_open) begin
        next_open_flags     = next_open_flags | open_evt;
        next_flags[FLG_OUT] = 1'b1;
        next_flags[FLG_ERR] = 1'b1;
      end
    end

    // [R1] [R14] init entry marks power-on
    if (state == LFM_INIT) begin
      next_flags[FLG_POR] = 1'b1;
      next_flags[FLG_ERR] = 1'b1;
    end

    // Configuration and flags return to defaults while held in reset state
    // [R14] registers to defaults
    if (state == LFM_POR) begin
      next_blank_code = BLANK_RESET;
      next_lowsup_th  = LOWSUP_RESET;
      next_flags      = '0;
      next_open_flags = '0;
    end

    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONFIG: begin
          next_rdata[CFG_LOWSUP_LSB +: LOWSUP_W] =
            low_supply_threshold_setting;
          next_rdata[CFG_BLANK_LSB +: BLANK_W] = blank_code;
        end
        ADDR_FLAGS: begin
          next_rdata[FLG_W-1:0] = flags;
        end
        ADDR_OPEN: begin
          next_rdata[N_CH-1:0] = open_flags;
        end
        ADDR_STATUS: begin
          next_rdata[ST_OUT_EN]      = channel_output_enable;
          next_rdata[ST_OPEN_EN]     = open_detect_enable;
          next_rdata[ST_ALERT]       = alert_oe_int;
          next_rdata[ST_PIN]         = alert_in;
          next_rdata[ST_STATE +: 3]  = state;
        end
        // Control bits self-clear, so they always read zero
        default: begin
          next_rdata = '0;
        end
      endcase
    end

    // [R9] [R13] outputs off on undervoltage or overtemp
    // [R11] [R17] no action on reference or open faults
    next_out_en  = (next_state == LFM_NORMAL) &&
                   !supply_uv_detect && !overtemp_detect;
    // [R7] open detection gated by low supply
    next_open_en = (next_state == LFM_NORMAL) && !low_supply_detect;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      blank_code                   <= BLANK_RESET;
      low_supply_threshold_setting <= LOWSUP_RESET;
      flags                        <= '0;
      open_flags                   <= '0;
      prev_lowsup                  <= 1'b0;
      prev_twarn                   <= 1'b0;
      reg_rdata                    <= '0;
      channel_output_enable        <= 1'b0;
      open_detect_enable           <= 1'b0;
      alert_out                    <= 1'b0;
    end else begin
      blank_code                   <= next_blank_code;
      low_supply_threshold_setting <= next_lowsup_th;
      flags                        <= next_flags;
      open_flags                   <= next_open_flags;
      prev_lowsup                  <= low_supply_detect;
      prev_twarn                   <= thermal_warn_detect;
      reg_rdata                    <= next_rdata;
      channel_output_enable        <= next_out_en;
      open_detect_enable           <= next_open_en;
      // Open-drain: the pin is only ever pulled low
      alert_out                    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- lfm_fault_monitor_props.sv
`default_nettype none
module lfm_fault_monitor_props
  import lfm_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              supply_ok,
  input wire logic              thermal_shutdown,
  input wire logic              low_supply_detect,
  input wire logic              supply_uv_detect,
  input wire logic              ref_fault_detect,
  input wire logic              thermal_warn_detect,
  input wire logic              overtemp_detect,
  input wire logic              alert_out,
  input wire logic              alert_oe,
  input wire logic              channel_output_enable,
  input wire logic              open_detect_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Three clean edges cover POR and INIT before faults are judged
  logic [2:0] ok_hist;
  logic       norm;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ok_hist <= 3'h0;
    end else begin
      ok_hist <= {ok_hist[1:0], supply_ok & ~thermal_shutdown};
    end
  end
  assign norm = (&ok_hist) & supply_ok & ~thermal_shutdown;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_warn_rise;
    norm && $past(norm) && $rose(thermal_warn_detect);
  endsequence
  sequence s_pulse_body;
    alert_oe [*8];
  endsequence

  a_warn_pulse: assert property (s_warn_rise |=> s_pulse_body)
    else $error("thermal warning pulse too short");
  a_lowsup_pulse: assert property (
    norm && $past(norm) && $rose(low_supply_detect) |=> alert_oe [*8])
    else $error("low supply pulse too short");
  a_uv_steady: assert property (norm && supply_uv_detect |=> alert_oe)
    else $error("undervoltage without alert");
  a_uv_out_off: assert property (
    norm && supply_uv_detect |=> !channel_output_enable)
    else $error("outputs on during undervoltage");
  a_ref_steady: assert property (
    norm && ref_fault_detect |=> alert_oe)
    else $error("reference fault without alert");
  a_otemp_off: assert property (
    norm && overtemp_detect |=> alert_oe && !channel_output_enable)
    else $error("overtemperature not handled");
  a_out_resume: assert property (
    norm && !supply_uv_detect && !overtemp_detect |=> channel_output_enable)
    else $error("outputs not enabled");
  a_open_gate: assert property (
    norm |=> open_detect_enable == !$past(low_supply_detect))
    else $error("open detect gating wrong");
  a_tsd_hold: assert property (
    thermal_shutdown |=> alert_oe && !channel_output_enable)
    else $error("thermal shutdown not handled");
  a_ctrl_zero: assert property (
    reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata == '0)
    else $error("clear bits read nonzero");
  a_pin_low: assert property (alert_oe |-> alert_out == 1'b0)
    else $error("alert pin not pulled low");
endmodule
`default_nettype wire

//--- lfm_fault_monitor_tb.sv
`default_nettype none
module lfm_fault_monitor_tb
  import lfm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 20;
  typedef struct packed {
    logic [4:0] src;
    logic [7:0] flg;
    logic       hold;
    logic       off;
  } lfm_row_t;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata, reg_rdata, d;
  logic                reg_wr, reg_rd, alert_in, alert_out, alert_oe;
  logic                mclk, rst, supply_ok, thermal_shutdown;
  logic                channel_output_enable, open_detect_enable;
  logic [LOWSUP_W-1:0] low_supply_threshold_setting;
  logic [NUM_CH-1:0]   pwm_on, headroom_low;
  logic [4:0]          flt;
  int                  n_errors, total_checks;
  lfm_row_t            rows [5] = '{'{5'h01, 8'h06, 1'b0, 1'b0},
    '{5'h02, 8'h0a, 1'b1, 1'b1}, '{5'h04, 8'h12, 1'b1, 1'b0},
    '{5'h08, 8'h22, 1'b0, 1'b0}, '{5'h10, 8'h42, 1'b1, 1'b1}};

  lfm_fault_monitor #(.PULSE_CYC(PC)) dut_u (.mclk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_ok,
    .thermal_shutdown, .low_supply_detect(flt[0]),
    .supply_uv_detect(flt[1]), .ref_fault_detect(flt[2]),
    .thermal_warn_detect(flt[3]), .overtemp_detect(flt[4]), .pwm_on,
    .headroom_low, .alert_in, .alert_out, .alert_oe,
    .low_supply_threshold_setting, .channel_output_enable,
    .open_detect_enable);
  lfm_master master_u (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);

  // Open-drain pin with pull-up
  assign alert_in = alert_oe ? alert_out : 1'b1;
  always #12.5 mclk = ~mclk;

  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    master_u.rd(a, d);
    chk(d, e);
  endtask
  // Entered in the time step of the edge that raised the event
  task automatic pulse_chk(input logic hold);
    cyc(1);
    @(negedge mclk) chk(alert_oe, 1);
    cyc(PC - 1);
    @(negedge mclk) chk(alert_oe, 1);
    cyc(1);
    @(negedge mclk) chk(alert_oe, hold);
  endtask

  initial begin
    #200us;
    n_errors++;
    complete_run();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    supply_ok = 1'b1;
    thermal_shutdown = 1'b0;
    flt = '0;
    pwm_on = '0;
    headroom_low = '0;
    n_errors = 0;
    total_checks = 0;
    cyc(12);
    rst <= 1'b0;
    cyc(3);
    rdchk(ADDR_FLAGS, 32'h03);
    rdchk(ADDR_STATUS, 32'h4b);
    rdchk(8'hfc, '0);
    rdchk(ADDR_CTRL, '0);
    master_u.wr(ADDR_CONFIG, '1);
    @(negedge mclk) chk(low_supply_threshold_setting, 5'h1f);
    rdchk(ADDR_CONFIG, 32'h0f1f);
    for (int i = 0; i < 2; i++) begin
      master_u.wr(ADDR_CONFIG, 32'h0305);
      @(posedge mclk) {thermal_shutdown, supply_ok} <= i ? 2'b00 : 2'b11;
      cyc(3);
      {thermal_shutdown, supply_ok} <= 2'b01;
      cyc(3);
      rdchk(ADDR_CONFIG, '0);
      rdchk(ADDR_FLAGS, 32'h03);
      master_u.wr(ADDR_CTRL, 32'h1);
      rdchk(ADDR_FLAGS, '0);
    end
    foreach (rows[i]) begin
      @(posedge mclk) flt <= rows[i].src;
      pulse_chk(rows[i].hold);
      chk(channel_output_enable, !rows[i].off);
      @(posedge mclk) flt <= '0;
      cyc(3);
      @(negedge mclk) chk({alert_oe, channel_output_enable}, 2'b01);
      rdchk(ADDR_FLAGS, rows[i].flg);
      master_u.clear_faults();
      rdchk(ADDR_FLAGS, '0);
    end
    @(posedge mclk) flt <= 5'h08;
    cyc(10);
    flt <= 5'h09;
    pulse_chk(1'b0);
    @(posedge mclk) flt <= 5'h02;
    master_u.clear_faults();
    // Undervoltage still present, so its flag and the summary survive
    rdchk(ADDR_FLAGS, 32'h0a);
    rdchk(ADDR_STATUS, 32'h46);
    @(posedge mclk) flt <= '0;
    cyc(2);
    master_u.clear_faults();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) begin
        flt <= 5'(i == 2);
        headroom_low <= '1;
        pwm_on <= 24'h000020;
      end
      cyc(i ? 200 : 100);
      pwm_on <= '0;
      headroom_low <= '0;
      @(negedge mclk) chk(channel_output_enable, 1);
      rdchk(ADDR_OPEN, i == 1 ? 32'h20 : '0);
      rdchk(ADDR_FLAGS, i == 1 ? 32'h82 : i ? 32'h06 : '0);
      @(posedge mclk) flt <= '0;
      cyc(2);
      master_u.clear_faults();
    end
    rdchk(ADDR_OPEN, '0);
    @(posedge mclk) rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(3);
    rdchk(ADDR_FLAGS, 32'h03);
    complete_run();
  end
endmodule

bind lfm_fault_monitor lfm_fault_monitor_props props_u (.mclk, .rst,
  .reg_addr, .reg_rd, .reg_rdata, .supply_ok, .thermal_shutdown,
  .low_supply_detect, .supply_uv_detect, .ref_fault_detect,
  .thermal_warn_detect, .overtemp_detect, .alert_out, .alert_oe,
  .channel_output_enable, .open_detect_enable);
`default_nettype wire

//--- lfm_master.sv
`default_nettype none
module lfm_master
  import lfm_pkg::*;
(
  input  wire logic              mclk,
  output var  logic [ADDR_W-1:0] reg_addr,
  output var  logic [DATA_W-1:0] reg_wdata,
  output var  logic              reg_wr,
  output var  logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // Stale data is inverted so nothing leans on a held bus
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // Clear once the fault has gone
  // Outputs stay under the master's control after a reference fault
  task automatic clear_faults();
    wr(ADDR_CTRL, 32'h3);
  endtask
endmodule
`default_nettype wire

//--- lfm_open_det.sv
`default_nettype none
module lfm_open_det
  import lfm_pkg::*;
#(
  parameter int CNT_W = MON_CNT_W
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             pwm_on,
  input  wire logic             headroom_low,
  input  wire logic             det_enable,
  input  wire logic [CNT_W-1:0] blank_cyc,
  input  wire logic [CNT_W-1:0] deg_cyc,
  output var  logic             open_evt
);

  logic [CNT_W-1:0] blank_cnt;
  logic [CNT_W-1:0] deg_cnt;
  logic             fired;
  logic [CNT_W-1:0] next_blank_cnt;
  logic [CNT_W-1:0] next_deg_cnt;
  logic             next_fired;
  logic             next_open_evt;

  always_comb begin
    next_blank_cnt = blank_cnt;
    next_deg_cnt   = '0;
    next_fired     = 1'b0;
    next_open_evt  = 1'b0;
    // [R15] only in on phase
    if (!pwm_on) begin
      next_blank_cnt = '0;
    end else if (blank_cnt < blank_cyc) begin
      // [R18] blanking after turn-on
      next_blank_cnt = blank_cnt + CNT_W'(1);
    end else if (headroom_low && det_enable) begin
      // [R16] deglitch then report once
      next_fired = fired;
      if (!fired) begin
        next_deg_cnt = deg_cnt + CNT_W'(1);
        if (next_deg_cnt >= deg_cyc) begin
          next_open_evt = 1'b1;
          next_fired    = 1'b1;
          next_deg_cnt  = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      blank_cnt <= '0;
      deg_cnt   <= '0;
      fired     <= 1'b0;
      open_evt  <= 1'b0;
    end else begin
      blank_cnt <= next_blank_cnt;
      deg_cnt   <= next_deg_cnt;
      fired     <= next_fired;
      open_evt  <= next_open_evt;
    end
  end

endmodule
`default_nettype wire

//--- lfm_pkg.sv
`default_nettype none
package lfm_pkg;

  localparam int CLK_MHZ = 40;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int NUM_CH  = 24;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_FLAGS  = 8'h08;
  localparam logic [7:0] ADDR_OPEN   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Control register bits (write-only strobes, read as zero)
  localparam int CTRL_POR_CLR_BIT   = 0;
  localparam int CTRL_FAULT_CLR_BIT = 1;

  // Configuration fields
  localparam int CFG_LOWSUP_LSB = 0;
  localparam int LOWSUP_W       = 5;
  localparam int CFG_BLANK_LSB  = 8;
  localparam int BLANK_W        = 4;
  localparam logic [LOWSUP_W-1:0] LOWSUP_RESET = 5'h00;
  localparam logic [BLANK_W-1:0]  BLANK_RESET  = 4'h0;

  // Flag register bit positions
  localparam int FLG_POR    = 0;
  localparam int FLG_ERR    = 1;
  localparam int FLG_LOWSUP = 2;
  localparam int FLG_SUPUV  = 3;
  localparam int FLG_REF    = 4;
  localparam int FLG_TWARN  = 5;
  localparam int FLG_OTEMP  = 6;
  localparam int FLG_OUT    = 7;
  localparam int FLG_W      = 8;

  // Status register bit positions
  localparam int ST_OUT_EN  = 0;
  localparam int ST_OPEN_EN = 1;
  localparam int ST_ALERT   = 2;
  localparam int ST_PIN     = 3;
  localparam int ST_STATE   = 4;

  // Timing
  localparam int ALERT_PULSE_US  = 50;
  localparam int ALERT_PULSE_CYC = ALERT_PULSE_US * CLK_MHZ;
  localparam int BLANK_STEP_NS   = 1000;
  localparam int BLANK_STEP_CYC  = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int OPEN_DEG_NS     = 2000;
  localparam int OPEN_DEG_CYC    = (OPEN_DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int MON_CNT_W       = 12;

  typedef enum logic [2:0] {
    LFM_POR    = 3'b001,
    LFM_INIT   = 3'b010,
    LFM_NORMAL = 3'b100
  } lfm_state_t;

  function automatic logic lfm_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage
`default_nettype wire
